// >>> eipt_pkg.sv
// Purpose: constants and types for the second extended interrupt priority register
// Assumes: one special-function register byte, visible on every register page
// Notes: arbitration that consumes the priority bits lives elsewhere
//
// Function
// RULE_01: bits 7 and 5 unused, read as zero, writes to them ignored.
// RULE_02: bit 6 picks low or high priority for serial port b.
// RULE_03: bit 4 picks low or high priority for converter b done.
// RULE_04: bit 3 picks low or high priority for converter b window compare.
// RULE_05: bits 2, 1, 0 pick priority for timer four, converter a done, timer three.
`default_nettype none

package eipt_pkg;

  // ***************************************
  // register map
  // ***************************************
  localparam logic [7:0] EIPT_PRIO_ADDR = 8'hF7;
  localparam logic [7:0] EIPT_PRIO_RESET = 8'h00;
  // writable bits; 7 and 5 have no storage
  localparam logic [7:0] EIPT_PRIO_WMASK = 8'h5F;

  // ***************************************
  // field positions
  // ***************************************
  localparam int EIPT_POS_SERIAL_B = 6;
  localparam int EIPT_POS_CONV_B_DONE = 4;
  localparam int EIPT_POS_CONV_B_WIN = 3;
  localparam int EIPT_POS_TIMER_FOUR = 2;
  localparam int EIPT_POS_CONV_A_DONE = 1;
  localparam int EIPT_POS_TIMER_THREE = 0;

  // ***************************************
  // carrier: one bit per source, 1 = high priority
  // ***************************************
  typedef struct packed {
    logic serial_port_b_prio;
    logic conv_b_done_prio;
    logic conv_b_window_prio;
    logic timer_four_prio;
    logic conv_a_done_prio;
    logic timer_three_prio;
  } eipt_prio_s;

endpackage : eipt_pkg

`default_nettype wire

// >>> eipt_prio_bit.sv
// Purpose: one stored priority bit with write enable
// Assumes: synchronous write strobe, asynchronous active-high reset
// Notes: reset value is a constant parameter
`timescale 1ns/10ps
`default_nettype none

module eipt_prio_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic wr_bit_i,
  output logic bit_o
);

  logic bit_reg;
  logic bit_next;

  always_comb begin
    bit_next = bit_reg;
    if (wr_en_i) begin
      bit_next = wr_bit_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_reg <= RESET_VAL;
    end else begin
      bit_reg <= bit_next;
    end
  end

  assign bit_o = bit_reg;

endmodule : eipt_prio_bit

`default_nettype wire

// >>> eipt_top.sv
// Purpose: second extended interrupt priority register on the special-function bus
// Assumes: bus inputs synchronous to CLK_SYS_I; register page ignored
// Notes: read data is registered, one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none

module eipt_top #(
  parameter int SFR_ADDR_W = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [SFR_ADDR_W-1:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_RVALID_O,
  output eipt_pkg::eipt_prio_s PRIO_O
);

  // ***************************************
  // elaboration checks
  // ***************************************
  if (SFR_ADDR_W != 8) begin : g_bad_addr_w
    $error("SFR_ADDR_W must be 8");
  end

  // every stored bit needs exactly one field in the carrier
  if ($countones(eipt_pkg::EIPT_PRIO_WMASK) != $bits(eipt_pkg::eipt_prio_s)) begin : g_bad_mask
    $error("write mask and priority carrier disagree");
  end

  // ***************************************
  // address decode
  // ***************************************
  logic wr_hit;
  logic rd_hit;
  // several generate branches drive single bits, so a net, not a variable
  wire logic [7:0] prio_bits;

  // page-independent register, so the page never enters the decode
  assign wr_hit = SFR_WR_I && (SFR_ADDR_I == eipt_pkg::EIPT_PRIO_ADDR);
  assign rd_hit = SFR_RD_I && (SFR_ADDR_I == eipt_pkg::EIPT_PRIO_ADDR);

  // ***************************************
  // storage
  // ***************************************
  for (genvar i = 0; i < 8; i++) begin : g_bit
    if (eipt_pkg::EIPT_PRIO_WMASK[i]) begin : g_store
      // bits 6, 4, 3, 2, 1, 0 hold a priority [RULE_02] [RULE_03] [RULE_04] [RULE_05]
      eipt_prio_bit #(
        .RESET_VAL(eipt_pkg::EIPT_PRIO_RESET[i])
      ) u_bit (
        .clk_i(CLK_SYS_I),
        .rst_i(RESET_I),
        .wr_en_i(wr_hit),
        .wr_bit_i(SFR_WDATA_I[i]),
        .bit_o(prio_bits[i])
      );
    end else begin : g_unused
      // no flop at all, so a write cannot land here [RULE_01]
      assign prio_bits[i] = 1'b0;
    end
  end

  // ***************************************
  // priority outputs
  // ***************************************
  always_comb begin
    PRIO_O.serial_port_b_prio = prio_bits[eipt_pkg::EIPT_POS_SERIAL_B]; // [RULE_02]
    PRIO_O.conv_b_done_prio = prio_bits[eipt_pkg::EIPT_POS_CONV_B_DONE]; // [RULE_03]
    PRIO_O.conv_b_window_prio = prio_bits[eipt_pkg::EIPT_POS_CONV_B_WIN]; // [RULE_04]
    PRIO_O.timer_four_prio = prio_bits[eipt_pkg::EIPT_POS_TIMER_FOUR]; // [RULE_05]
    PRIO_O.conv_a_done_prio = prio_bits[eipt_pkg::EIPT_POS_CONV_A_DONE]; // [RULE_05]
    PRIO_O.timer_three_prio = prio_bits[eipt_pkg::EIPT_POS_TIMER_THREE]; // [RULE_05]
  end

  // ***************************************
  // read port
  // ***************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = 1'b0;
    if (rd_hit) begin
      // mask again so unused bits read zero even if storage changes [RULE_01]
      rdata_next = prio_bits & eipt_pkg::EIPT_PRIO_WMASK;
      rvalid_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign SFR_RDATA_O = rdata_reg;
  assign SFR_RVALID_O = rvalid_reg;

  // ***************************************
  // assertions
  // ***************************************
  property p_unused_read_zero;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      (SFR_RDATA_O[7] == 1'b0) && (SFR_RDATA_O[5] == 1'b0);
  endproperty
  a_unused_read_zero: assert property (p_unused_read_zero) // [RULE_01]
    else $error("unused bit read back as one");

  property p_write_masked;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit ##1 rd_hit |=>
        SFR_RDATA_O == ($past(SFR_WDATA_I, 2) & eipt_pkg::EIPT_PRIO_WMASK);
  endproperty
  a_write_masked: assert property (p_write_masked) // [RULE_01]
    else $error("written byte not read back masked");

  property p_serial_b;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit |=> PRIO_O.serial_port_b_prio == $past(SFR_WDATA_I[6]);
  endproperty
  a_serial_b: assert property (p_serial_b) // [RULE_02]
    else $error("serial port b priority not taken from bit 6");

  property p_conv_b_done;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit |=> PRIO_O.conv_b_done_prio == $past(SFR_WDATA_I[4]);
  endproperty
  a_conv_b_done: assert property (p_conv_b_done) // [RULE_03]
    else $error("converter b done priority not taken from bit 4");

  property p_conv_b_window;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit |=> PRIO_O.conv_b_window_prio == $past(SFR_WDATA_I[3]);
  endproperty
  a_conv_b_window: assert property (p_conv_b_window) // [RULE_04]
    else $error("converter b window priority not taken from bit 3");

  property p_low_three;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit |=> {PRIO_O.timer_four_prio, PRIO_O.conv_a_done_prio,
                  PRIO_O.timer_three_prio} == $past(SFR_WDATA_I[2:0]);
  endproperty
  a_low_three: assert property (p_low_three) // [RULE_05]
    else $error("timer or converter a priority not taken from bits 2..0");

  property p_hold;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      !wr_hit [*2] |=> $stable(PRIO_O);
  endproperty
  a_hold: assert property (p_hold) // [RULE_02]
    else $error("priority changed without a write");

  property p_read_timing;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      rd_hit |=> SFR_RVALID_O &&
        (SFR_RDATA_O[6] == $past(PRIO_O.serial_port_b_prio)) &&
        (SFR_RDATA_O[2:0] == $past({PRIO_O.timer_four_prio,
          PRIO_O.conv_a_done_prio, PRIO_O.timer_three_prio}));
  endproperty
  a_read_timing: assert property (p_read_timing) // [RULE_05]
    else $error("read answer wrong or late");

  property p_idle_read;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      !rd_hit |=> !SFR_RVALID_O && (SFR_RDATA_O == 8'h00);
  endproperty
  a_idle_read: assert property (p_idle_read) // [RULE_01]
    else $error("read answer without a read");

  property p_reset_clear;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      $fell(RESET_I) |-> !SFR_RVALID_O &&
        ((prio_bits & eipt_pkg::EIPT_PRIO_WMASK) ==
         (eipt_pkg::EIPT_PRIO_RESET & eipt_pkg::EIPT_PRIO_WMASK));
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RULE_05]
    else $error("priorities not at reset value after reset");

  property p_read_conv_b_done;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      rd_hit |=> SFR_RDATA_O[4] == $past(PRIO_O.conv_b_done_prio);
  endproperty
  a_read_conv_b_done: assert property (p_read_conv_b_done) // [RULE_03]
    else $error("converter b done priority not read back at bit 4");

  property p_read_conv_b_window;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      rd_hit |=> SFR_RDATA_O[3] == $past(PRIO_O.conv_b_window_prio);
  endproperty
  a_read_conv_b_window: assert property (p_read_conv_b_window) // [RULE_04]
    else $error("converter b window priority not read back at bit 3");

  property p_unused_no_store;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_hit |=> (prio_bits[7] == 1'b0) && (prio_bits[5] == 1'b0);
  endproperty
  a_unused_no_store: assert property (p_unused_no_store) // [RULE_01]
    else $error("unused bit stored a written one");

  property p_unmapped_write;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      SFR_WR_I && !wr_hit |=> $stable(PRIO_O);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) // [RULE_02]
    else $error("write to another address changed a priority");

  property p_read_no_effect;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      rd_hit && !wr_hit |=> $stable(PRIO_O);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) // [RULE_05]
    else $error("a read disturbed a priority");

  property p_rvalid_pulse;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
      SFR_RVALID_O && !rd_hit |=> !SFR_RVALID_O;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) // [RULE_01]
    else $error("read answer stood longer than one cycle");

endmodule : eipt_top

`default_nettype wire

// >>> tb_eipt_top.sv
// Purpose: self-checking bench for the second extended priority register
// Assumes: read answer one cycle after the strobe; inputs move on falling edges
// Notes: register assertions live in the design files
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  eipt_pkg::eipt_prio_s prio;
  int n_errors = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  eipt_top u_eipt_top (
    .CLK_SYS_I(clk),
    .RESET_I(rst),
    .SFR_ADDR_I(addr),
    .SFR_WR_I(wr),
    .SFR_RD_I(rd),
    .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(rdata),
    .SFR_RVALID_O(rvalid),
    .PRIO_O(prio)
  );

  // ***************************************
  // helpers
  // ***************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // priority outputs as the register byte would place them
  function automatic logic [7:0] prio_byte();
    return {1'b0, prio[5], 1'b0, prio[4:0]};
  endfunction : prio_byte

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  // hit=0 expects no answer at all
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check("rvalid", {7'h00, rvalid}, {7'h00, hit});
    check("rdata", rdata, hit ? exp : 8'h00);
    @(negedge clk);
    check("rvalid_drop", {7'h00, rvalid}, 8'h00);
    check("rdata_drop", rdata, 8'h00);
  endtask : rd_reg

  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ***************************************
  // sequence
  // ***************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check("prio_reset", prio_byte(), 8'h00);
    rd_reg(8'hF7, 8'h00, 1'b1);
    // walking one over every bit, unused ones must vanish
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'hF7, 8'h01 << i);
      check("prio_walk", prio_byte(), (8'h01 << i) & 8'h5F);
      rd_reg(8'hF7, (8'h01 << i) & 8'h5F, 1'b1);
    end
    // write then read with no gap: the read sees the fresh byte
    @(negedge clk);
    addr = 8'hF7;
    wdata = 8'hFA;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check("rdata_b2b", rdata, 8'h5A);
    check("rvalid_b2b", {7'h00, rvalid}, 8'h01);
    wr_reg(8'hF7, 8'hFF);
    check("prio_ones", prio_byte(), 8'h5F);
    rd_reg(8'hF7, 8'h5F, 1'b1);
    // neighbour address must neither store nor answer
    wr_reg(8'hF6, 8'h00);
    check("prio_unmapped", prio_byte(), 8'h5F);
    rd_reg(8'hF6, 8'h00, 1'b0);
    // read and write together: old value first, new one a cycle later
    @(negedge clk);
    addr = 8'hF7;
    wdata = 8'hB5;
    wr = 1'b1;
    rd = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    check("rdata_old", rdata, 8'h5F);
    check("prio_new", prio_byte(), 8'h15);
    rd_reg(8'hF7, 8'h15, 1'b1);
    // reset in mid-run clears all priorities
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check("prio_rerst", prio_byte(), 8'h00);
    rst = 1'b0;
    rd_reg(8'hF7, 8'h00, 1'b1);
    results();
  end
endmodule : tb_top

`default_nettype wire
